// File: verilog/corf_rf_top.sv
/*
  Core operand register file: sixteen globals, a cache of local sets
  switched on call and return, literal operands, scoreboard, fault check
  and the two mapped identity words.
  Assumes issue and execution logic on the same clock and reset, and no
  call or return while results are outstanding.
*/
`include "corf_regs.svh"

module corf_rf_top #(
  parameter logic [31:0] CORE_ID    = 32'h0000_1234, // arbitrary value
  parameter logic [31:0] CHIP_ID    = 32'h0000_5678, // arbitrary value
  parameter int          FRAME_BITS = 2
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  // issue
  input  wire logic                    issueVld,
  output logic                         issueStall,
  input  corf_pkg::corf_opkind_t       srcAKind,
  input  wire logic [4:0]              srcAIdx,
  input  corf_pkg::corf_grp_t          srcALen,
  input  corf_pkg::corf_opkind_t       srcBKind,
  input  wire logic [4:0]              srcBIdx,
  input  corf_pkg::corf_grp_t          srcBLen,
  input  wire logic                    dstEn,
  input  corf_pkg::corf_opkind_t       dstKind,
  input  wire logic [3:0]              dstIdx,
  input  corf_pkg::corf_grp_t          dstLen,
  // operands
  output logic                         opVld,
  output logic [`CORF_OPND_W-1:0]      opAData,
  output logic [`CORF_OPND_W-1:0]      opBData,
  output logic                         misalignFault,
  // result write
  input  wire logic                    wbVld,
  input  corf_pkg::corf_opkind_t       wbKind,
  input  wire logic [3:0]              wbIdx,
  input  corf_pkg::corf_grp_t          wbLen,
  input  wire logic [`CORF_OPND_W-1:0] wbData,
  // procedure call and return
  input  wire logic                    callReq,
  input  wire logic                    retReq,
  input  wire logic [31:0]             callNewFp,
  input  wire logic [31:0]             callNewSp,
  input  wire logic [31:0]             callRetIp,
  output logic                         frameStall,
  output logic [FRAME_BITS-1:0]        frameDepth,
  // mapped identity read
  input  wire logic                    mmrRdEn,
  input  wire logic [31:0]             mmrAddr,
  output logic [31:0]                  mmrRdData,
  output logic                         mmrHit,
  // status
  output logic [31:0]                  sbBusy
);

  localparam int NSETS = 1 << FRAME_BITS;
  localparam logic [FRAME_BITS-1:0] MAX_DEPTH = '1;
  logic [31:0]                 gReg [`CORF_NUM_REGS];
  logic [31:0]                 lReg [NSETS*`CORF_NUM_REGS];
  logic [FRAME_BITS-1:0]       frameDepth_r, depthUp;
  logic                        opVld_r, misalign_r, mmrHit_r, gZeroWritten;
  logic                        issueTake, callTake, retTake, badRef;
  logic [`CORF_OPND_W-1:0]     opAData_r, opBData_r, litA, litB;
  logic [31:0]                 mmrRdData_r, curPfp;
  logic [31:0]                 aMask, bMask, dMask, wMask, sbSet, sbClr;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // busy bits of a reference: globals low half, current locals high half
  function automatic logic [31:0] grpMask(corf_pkg::corf_opkind_t kind,
                                          logic [3:0] idx, corf_pkg::corf_grp_t len);
    logic [31:0] m;
    logic [3:0]  w;
    m = '0;
    w = '0;
    for (int k = 0; k < 4; k++) begin
      w = idx + 4'(k);
      if (kind != corf_pkg::OPK_LITERAL && 2'(k) <= len) begin
        m[{kind == corf_pkg::OPK_LOCAL, w}] = 1'b1;
      end
    end
    return m;
  endfunction

  // alignment of a multi-register reference
  function automatic logic misaligned(corf_pkg::corf_opkind_t kind, logic [3:0] idx,
                                      corf_pkg::corf_grp_t len);
    logic bad;
    bad = 1'b0;
    if (kind != corf_pkg::OPK_LITERAL) begin
      if (len == corf_pkg::GRP_TWO) begin
        bad = idx[0];
      end else if (len != corf_pkg::GRP_ONE) begin
        bad = idx[1:0] != 2'h0;
      end
    end
    return bad;
  endfunction

  // register words of a reference, unused upper words zero
  function automatic logic [`CORF_OPND_W-1:0] opFetch(corf_pkg::corf_opkind_t kind,
                                                      logic [3:0] idx,
                                                      corf_pkg::corf_grp_t len);
    logic [`CORF_OPND_W-1:0] v;
    logic [3:0]              w;
    v = '0;
    w = '0;
    for (int k = 0; k < 4; k++) begin
      w = idx + 4'(k);
      if (2'(k) <= len) begin
        v[32*k +: 32] = (kind == corf_pkg::OPK_LOCAL) ? lReg[{frameDepth_r, w}] : gReg[w];
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // issue and scoreboard
  assign aMask = grpMask(srcAKind, srcAIdx[3:0], srcALen);
  assign bMask = grpMask(srcBKind, srcBIdx[3:0], srcBLen);
  assign dMask = dstEn ? grpMask(dstKind, dstIdx, dstLen) : 32'h0;
  assign wMask = grpMask(wbKind, wbIdx, wbLen);

  // overlap with busy bits or a call or return request stalls; independent work flows on
  assign issueStall = issueVld &&
                      (((sbBusy & (aMask | bMask | dMask)) != 32'h0) || callReq || retReq);
  assign issueTake  = issueVld && !issueStall;
  assign sbSet      = issueTake ? dMask : 32'h0;
  assign sbClr      = wbVld ? wMask : 32'h0;

  corf_scoreboard #(.N(32)) u_sb (
    .sys_clk(sys_clk),
    .arst_n (arst_n),
    .setMask(sbSet),
    .clrMask(sbClr),
    .busy   (sbBusy)
  );

  assign badRef = misaligned(srcAKind, srcAIdx[3:0], srcALen) ||
                  misaligned(srcBKind, srcBIdx[3:0], srcBLen) ||
                  (dstEn && misaligned(dstKind, dstIdx, dstLen));

  ////////////////////////////////////////////////////////////////////////
  // operand read
  corf_literal_expand #(.OUT_W(`CORF_OPND_W)) u_litA (
    .lit   (srcAIdx),
    .litExt(litA)
  );

  corf_literal_expand #(.OUT_W(`CORF_OPND_W)) u_litB (
    .lit   (srcBIdx),
    .litExt(litB)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      opVld_r    <= 1'b0;
      opAData_r  <= '0;
      opBData_r  <= '0;
      misalign_r <= 1'b0;
    end else begin
      opVld_r    <= issueTake;
      misalign_r <= issueTake && badRef;
      if (issueTake) begin
        // literal used whole-width, never sign-extended
        opAData_r <= (srcAKind == corf_pkg::OPK_LITERAL) ? litA
                     : opFetch(srcAKind, srcAIdx[3:0], srcALen);
        opBData_r <= (srcBKind == corf_pkg::OPK_LITERAL) ? litB
                     : opFetch(srcBKind, srcBIdx[3:0], srcBLen);
      end
    end
  end

  assign opVld         = opVld_r;
  assign opAData       = opAData_r;
  assign opBData       = opBData_r;
  assign misalignFault = misalign_r;

  ////////////////////////////////////////////////////////////////////////
  // call and return
  // frame switch only with nothing outstanding, so no busy local moves
  assign callTake   = callReq && sbBusy == 32'h0 && frameDepth_r != MAX_DEPTH;
  assign retTake    = retReq && !callReq && sbBusy == 32'h0 && frameDepth_r != '0;
  assign frameStall = (callReq || retReq) && !(callTake || retTake);
  assign depthUp    = frameDepth_r + 1'b1;
  assign curPfp     = lReg[{frameDepth_r, `CORF_PFP_IDX}];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameDepth_r <= '0;
    end else if (callTake) begin
      frameDepth_r <= depthUp;
    end else if (retTake) begin
      frameDepth_r <= frameDepth_r - 1'b1;
    end
  end

  assign frameDepth = frameDepth_r;

  ////////////////////////////////////////////////////////////////////////
  // global registers
  // only result writes and frame pointer moves touch globals
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `CORF_NUM_REGS; i++) begin
        gReg[i] <= (i == 0) ? CORE_ID : 32'h0;
      end
    end else begin
      if (wbVld && wbKind == corf_pkg::OPK_GLOBAL) begin
        for (int k = 0; k < 4; k++) begin
          if (2'(k) <= wbLen) begin
            gReg[wbIdx + 4'(k)] <= wbData[32*k +: 32];
          end
        end
      end
      if (callTake) begin
        gReg[`CORF_FP_IDX] <= callNewFp;
      end else if (retTake) begin
        gReg[`CORF_FP_IDX] <= curPfp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // local register sets
  // no reset and no clearing: a fresh set holds stale data outside its saved fp, sp and return ip slots
  always_ff @(posedge sys_clk) begin
    if (wbVld && wbKind == corf_pkg::OPK_LOCAL) begin
      for (int k = 0; k < 4; k++) begin
        if (2'(k) <= wbLen) begin
          lReg[{frameDepth_r, wbIdx + 4'(k)}] <= wbData[32*k +: 32];
        end
      end
    end
    if (callTake) begin
      lReg[{depthUp, `CORF_PFP_IDX}] <= gReg[`CORF_FP_IDX];
      lReg[{depthUp, `CORF_SP_IDX}]  <= callNewSp;
      lReg[{depthUp, `CORF_RIP_IDX}] <= callRetIp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mapped identity words
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mmrRdData_r <= 32'h0;
      mmrHit_r    <= 1'b0;
    end else begin
      mmrHit_r    <= mmrRdEn && (mmrAddr == `CORF_CORE_ID_ADDR ||
                                 mmrAddr == `CORF_CHIP_ID_ADDR);
      mmrRdData_r <= !mmrRdEn                          ? 32'h0 :
                     mmrAddr == `CORF_CORE_ID_ADDR ? CORE_ID :
                     mmrAddr == `CORF_CHIP_ID_ADDR ? CHIP_ID :
                     32'h0;
    end
  end

  assign mmrRdData = mmrRdData_r;
  assign mmrHit    = mmrHit_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gZeroWritten <= 1'b0;
    end else if (wbVld && wbKind == corf_pkg::OPK_GLOBAL && wMask[0]) begin
      gZeroWritten <= 1'b1;
    end
  end

  AST_GZERO_ID:   assert property (!gZeroWritten |-> gReg[0] == CORE_ID)
    else $error("global_zero lost identity word");
  AST_MMR_CORE:   assert property (mmrRdEn && mmrAddr == `CORF_CORE_ID_ADDR
                                   |=> mmrHit && mmrRdData == CORE_ID)
    else $error("core identity read wrong");
  AST_CALL_FP:    assert property (callTake |=> gReg[15] == $past(callNewFp)
                                   && curPfp == $past(gReg[15]))
    else $error("call frame pointer handoff wrong");
  AST_RET_FP:     assert property (retTake |=> gReg[15] == $past(curPfp)
                                   && frameDepth == $past(frameDepth) - 1'b1)
    else $error("return did not restore frame pointer");
  AST_GLOBAL_KEEP: assert property (callTake && !wbVld |=> gReg[1] == $past(gReg[1]))
    else $error("global changed across call");
  AST_STALL:      assert property (issueVld && (sbBusy & (aMask | bMask | dMask))
                                   != 32'h0 |-> issueStall)
    else $error("busy register not blocked");
  AST_NO_STALL:   assert property (issueVld && !callReq && !retReq
                                   && (sbBusy & (aMask | bMask | dMask)) == 32'h0
                                   |-> !issueStall)
    else $error("independent issue stalled");
  AST_SB_SET:     assert property (issueTake && dstEn |=> (sbBusy & $past(dMask))
                                   == $past(dMask))
    else $error("destination not marked busy");
  AST_SB_CLR:     assert property (wbVld && (sbSet & wMask) == 32'h0
                                   |=> (sbBusy & $past(wMask)) == 32'h0)
    else $error("busy bit not cleared on write");
  AST_LIT:        assert property (issueTake && srcAKind == corf_pkg::OPK_LITERAL
                                   |=> opVld && opAData == {123'h0, $past(srcAIdx)})
    else $error("literal not zero-extended");
  AST_MISALIGN:   assert property (issueTake && dstEn && dstKind != corf_pkg::OPK_LITERAL
                                   && dstLen == corf_pkg::GRP_TWO && dstIdx[0]
                                   |=> misalignFault)
    else $error("misaligned pair not faulted");

  COV_CALL:  cover property (callTake ##[1:20] retTake);
  COV_STALL: cover property (issueStall ##1 issueTake);
  COV_LIT:   cover property (issueTake && srcAKind == corf_pkg::OPK_LITERAL && srcAIdx == 5'h1f);
  COV_CLR:   cover property (wbVld && issueTake);

endmodule

// File: verilog/corf_regs.svh
/*
  Constants for the core operand register file: mapped identity offsets,
  register counts, dedicated slot numbers and widths.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef CORF_REGS_SVH
`define CORF_REGS_SVH

`define CORF_CORE_ID_ADDR 32'hff008710
`define CORF_CHIP_ID_ADDR 32'h00001710
`define CORF_WORD_W       32
`define CORF_LIT_W        5
`define CORF_OPND_W       128
`define CORF_NUM_REGS     16
`define CORF_GID_IDX      4'h0
`define CORF_FP_IDX       4'hf
`define CORF_PFP_IDX      4'h0
`define CORF_SP_IDX       4'h1
`define CORF_RIP_IDX      4'h2

`endif

// File: verilog/corf_pkg.sv
/*
  Types of the core operand register file: operand source kinds and
  register group sizes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package corf_pkg;

  // operand source kind
  typedef enum logic [1:0] {
    OPK_GLOBAL  = 2'h0,
    OPK_LOCAL   = 2'h1,
    OPK_LITERAL = 2'h3
  } corf_opkind_t;

  // number of consecutive registers in a reference, minus one
  typedef enum logic [1:0] {
    GRP_ONE   = 2'h0,
    GRP_TWO   = 2'h1,
    GRP_THREE = 2'h2,
    GRP_FOUR  = 2'h3
  } corf_grp_t;

endpackage

// File: verilog/corf_literal_expand.sv
/*
  Literal expander: a 5-bit unsigned literal widened with leading zeros.
  Assumes the consumer reads it as unsigned or non-negative.
*/
`include "corf_regs.svh"

module corf_literal_expand #(
  parameter int OUT_W = `CORF_OPND_W
) (
  // literal in
  input  wire logic [`CORF_LIT_W-1:0] lit,
  // widened value
  output wire logic [OUT_W-1:0]       litExt
);

  // never sign-extended, so a signed consumer sees 0..31 only
  assign litExt = {{(OUT_W-`CORF_LIT_W){1'b0}}, lit};

endmodule

// File: verilog/corf_scoreboard.sv
/*
  Register scoreboard: one busy bit per register, set when a writer
  issues and cleared when its result lands.
  Assumes the issue logic stalls any reader or writer of a busy bit.
*/
module corf_scoreboard #(
  parameter int N = 32
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // set and clear masks
  input  wire logic [N-1:0] setMask,
  input  wire logic [N-1:0] clrMask,
  // busy bits
  output logic [N-1:0]      busy
);

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= '0;
    end else begin
      busy <= (busy & ~clrMask) | setMask;
    end
  end

endmodule

// File: bench/corf_exec_model.sv
/*
  Execution unit stand-in: takes a result command from the bench, waits the
  given cycles, then writes the result back for one cycle.
  Assumes the bench has issued the matching writer before the command.
*/
module corf_exec_model (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // command from the bench
  input  wire logic              cmdVld,
  input  wire logic [3:0]        cmdLat,
  input  corf_pkg::corf_opkind_t cmdKind,
  input  wire logic [3:0]        cmdIdx,
  input  corf_pkg::corf_grp_t    cmdLen,
  input  wire logic [127:0]      cmdData,
  // result write
  output logic                   wbVld,
  output corf_pkg::corf_opkind_t wbKind,
  output logic [3:0]             wbIdx,
  output corf_pkg::corf_grp_t    wbLen,
  output logic [127:0]           wbData
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0]   cnt_r;
  logic         pend_r;
  logic [127:0] data_r;

  //////////////////////////////////////////////////////////////////////////
  // groups are commanded as given, misaligned ones included
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_r <= 1'b0;
      cnt_r  <= 4'h0;
      data_r <= 128'h0;
      wbVld  <= 1'b0;
      wbKind <= corf_pkg::OPK_GLOBAL;
      wbIdx  <= 4'h0;
      wbLen  <= corf_pkg::GRP_ONE;
      wbData <= 128'h0;
    end else begin
      wbVld  <= 1'b0;
      // idle data keeps moving so a stale word never looks valid
      wbData <= ~wbData;
      if (cmdVld) begin
        pend_r <= 1'b1;
        cnt_r  <= cmdLat;
        data_r <= cmdData;
        wbKind <= cmdKind;
        wbIdx  <= cmdIdx;
        wbLen  <= cmdLen;
      end else if (pend_r && cnt_r == 4'h0) begin
        pend_r <= 1'b0;
        wbVld  <= 1'b1;
        wbData <= data_r;
      end else if (pend_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

// File: bench/corf_rf_top_tb_top.sv
/*
  Self-checking bench of the operand register file: issue, result write,
  call and return, literal and identity-word reads.
  Assumes the register file top and the execution stand-in model.
*/
module corf_rf_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] CORE_V = 32'h0000_a5c3; // arbitrary value
  localparam logic [31:0] CHIP_V = 32'h0000_3c5a; // arbitrary value
  localparam corf_pkg::corf_opkind_t GL = corf_pkg::OPK_GLOBAL;
  localparam corf_pkg::corf_opkind_t LC = corf_pkg::OPK_LOCAL;
  localparam corf_pkg::corf_opkind_t LT = corf_pkg::OPK_LITERAL;
  localparam corf_pkg::corf_grp_t    G1 = corf_pkg::GRP_ONE;
  localparam corf_pkg::corf_grp_t    G2 = corf_pkg::GRP_TWO;
  localparam corf_pkg::corf_grp_t    G3 = corf_pkg::GRP_THREE;
  localparam corf_pkg::corf_grp_t    G4 = corf_pkg::GRP_FOUR;

  logic sys_clk, arst_n, issueVld, issueStall, dstEn, opVld, misalignFault;
  logic wbVld, callReq, retReq, frameStall, mmrRdEn, mmrHit, cmdVld;
  corf_pkg::corf_opkind_t srcAKind, srcBKind, dstKind, wbKind, cmdKind;
  corf_pkg::corf_grp_t    srcALen, srcBLen, dstLen, wbLen, cmdLen;
  logic [4:0]   srcAIdx, srcBIdx;
  logic [3:0]   dstIdx, wbIdx, cmdIdx, cmdLat;
  logic [127:0] opAData, opBData, wbData, cmdData;
  logic [31:0]  callNewFp, callNewSp, callRetIp, mmrAddr, mmrRdData, sbBusy;
  logic [1:0]   frameDepth;
  int           err_total, n_checks, cyc, ns;

  corf_rf_top #(.CORE_ID(CORE_V), .CHIP_ID(CHIP_V), .FRAME_BITS(2)) uut (
    .sys_clk, .arst_n, .issueVld, .issueStall, .srcAKind, .srcAIdx, .srcALen,
    .srcBKind, .srcBIdx, .srcBLen, .dstEn, .dstKind, .dstIdx, .dstLen, .opVld,
    .opAData, .opBData, .misalignFault, .wbVld, .wbKind, .wbIdx, .wbLen, .wbData,
    .callReq, .retReq, .callNewFp, .callNewSp, .callRetIp, .frameStall,
    .frameDepth, .mmrRdEn, .mmrAddr, .mmrRdData, .mmrHit, .sbBusy);

  corf_exec_model mdl (.sys_clk, .arst_n, .cmdVld, .cmdLat, .cmdKind, .cmdIdx,
    .cmdLen, .cmdData, .wbVld, .wbKind, .wbIdx, .wbLen, .wbData);

  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until taken; each task but exec first lets a falling edge pass so
  // no strobe drops and rises again in one time step
  task automatic issue(input corf_pkg::corf_opkind_t ak, input logic [4:0] ai,
      input corf_pkg::corf_grp_t al, input corf_pkg::corf_opkind_t bk,
      input logic [4:0] bi, input logic de, input corf_pkg::corf_opkind_t dk,
      input logic [3:0] di, input corf_pkg::corf_grp_t dl, input logic mf);
    @(negedge sys_clk);
    srcAKind = ak;
    srcAIdx = ai;
    srcALen = al;
    srcBKind = bk;
    srcBIdx = bi;
    dstEn = de;
    dstKind = dk;
    dstIdx = di;
    dstLen = dl;
    issueVld = 1'b1;
    ns = 0;
    #1;
    while (issueStall !== 1'b0 && ns < 50) begin
      @(negedge sys_clk);
      ns++;
    end
    @(negedge sys_clk);
    issueVld = 1'b0;
    dstEn = 1'b0;
    chk(128'(opVld), 128'h1);
    chk(128'(misalignFault), 128'(mf));
  endtask

  task automatic exec(input corf_pkg::corf_opkind_t k, input logic [3:0] i,
      input corf_pkg::corf_grp_t l, input logic [127:0] d, input logic [3:0] lat);
    cmdVld = 1'b1;
    cmdLat = lat;
    cmdKind = k;
    cmdIdx = i;
    cmdLen = l;
    cmdData = d;
    @(negedge sys_clk);
    cmdVld = 1'b0;
  endtask

  task automatic wr(input corf_pkg::corf_opkind_t k, input logic [3:0] i,
      input corf_pkg::corf_grp_t l, input logic [127:0] d);
    issue(LT, 5'h0, G1, LT, 5'h0, 1'b1, k, i, l, 1'b0);
    exec(k, i, l, d, 4'h0);
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic rd(input corf_pkg::corf_opkind_t k, input logic [3:0] i,
      input corf_pkg::corf_grp_t l, input logic [127:0] e);
    issue(k, {1'b0, i}, l, LT, 5'h0, 1'b0, GL, 4'h0, G1, 1'b0);
    chk(opAData, e);
  endtask

  task automatic mmr(input logic [31:0] a, input logic [31:0] d, input logic h);
    @(negedge sys_clk);
    mmrRdEn = 1'b1;
    mmrAddr = a;
    @(negedge sys_clk);
    mmrRdEn = 1'b0;
    mmrAddr = ~a;
    chk(128'(mmrRdData), 128'(d));
    chk(128'(mmrHit), 128'(h));
  endtask

  task automatic frame(input logic c, input logic [31:0] fp, input logic rf,
      input logic [1:0] dexp);
    @(negedge sys_clk);
    callReq = c;
    retReq = !c;
    callNewFp = fp;
    callNewSp = fp + 32'h40;
    callRetIp = fp + 32'h100;
    #1;
    chk(128'(frameStall), 128'(rf));
    @(negedge sys_clk);
    callReq = 1'b0;
    retReq = 1'b0;
    chk(128'(frameDepth), 128'(dexp));
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, issueVld, dstEn, callReq, retReq, mmrRdEn, cmdVld} = 7'h0;
    srcAKind = GL;
    srcBKind = GL;
    dstKind = GL;
    cmdKind = GL;
    srcALen = G1;
    srcBLen = G1;
    dstLen = G1;
    cmdLen = G1;
    {srcAIdx, srcBIdx, dstIdx, cmdIdx, cmdLat} = 26'h0;
    {cmdData, callNewFp, callNewSp, callRetIp, mmrAddr} = 256'h0;
    {err_total, n_checks, cyc} = 96'h0;
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    rd(GL, 4'h0, G1, 128'(CORE_V));
    mmr(32'hff008710, CORE_V, 1'b1);
    mmr(32'h00001710, CHIP_V, 1'b1);
    mmr(32'h00001714, 32'h0, 1'b0);
    for (int v = 0; v < 32; v += 5) begin
      issue(LT, 5'(v), G4, LT, 5'(31 - v), 1'b0, GL, 4'h0, G1, 1'b0);
      chk(opAData, 128'(v));
      chk(opBData, 128'(31 - v));
    end
    wr(GL, 4'h4, G4, 128'h44_0000_0033_0000_0022_0000_0011);
    issue(GL, 5'h2, G2, GL, 5'h3, 1'b0, GL, 4'h0, G1, 1'b0);
    issue(GL, 5'h3, G2, LT, 5'h0, 1'b0, GL, 4'h0, G1, 1'b1);
    issue(GL, 5'h6, G4, LT, 5'h0, 1'b0, GL, 4'h0, G1, 1'b1);
    issue(GL, 5'h8, G3, LT, 5'h0, 1'b0, GL, 4'h0, G1, 1'b0);
    issue(LT, 5'h0, G1, LT, 5'h0, 1'b1, GL, 4'h9, G2, 1'b1);
    exec(GL, 4'h9, G2, 128'h0, 4'h0);
    repeat (2) @(negedge sys_clk);
    // long writer of g8, then an independent and a dependent reader
    issue(LT, 5'h0, G1, LT, 5'h0, 1'b1, GL, 4'h8, G1, 1'b0);
    chk(128'(sbBusy), 128'h100);
    exec(GL, 4'h8, G1, 128'h5a, 4'h6);
    issue(GL, 5'h4, G1, LT, 5'h1, 1'b0, GL, 4'h0, G1, 1'b0);
    chk(128'(ns), 128'h0);
    issue(GL, 5'h8, G1, LT, 5'h1, 1'b0, GL, 4'h0, G1, 1'b0);
    chk(128'(ns > 2), 128'h1);
    chk(opAData, 128'h5a);
    chk(128'(sbBusy), 128'h0);
    wr(GL, 4'hf, G1, 128'h1000);
    wr(LC, 4'h5, G1, 128'h11);
    frame(1'b1, 32'h2000, 1'b0, 2'h1);
    rd(GL, 4'hf, G1, 128'h2000);
    rd(LC, 4'h0, G3, {32'h0, 32'h2100, 32'h2040, 32'h1000});
    rd(GL, 4'h4, G4, 128'h44_0000_0033_0000_0022_0000_0011);
    wr(LC, 4'h5, G1, 128'h22);
    frame(1'b1, 32'h3000, 1'b0, 2'h2);
    frame(1'b1, 32'h4000, 1'b0, 2'h3);
    frame(1'b1, 32'h5000, 1'b1, 2'h3);
    frame(1'b0, 32'h0, 1'b0, 2'h2);
    rd(GL, 4'hf, G1, 128'h3000);
    frame(1'b0, 32'h0, 1'b0, 2'h1);
    frame(1'b0, 32'h0, 1'b0, 2'h0);
    rd(GL, 4'hf, G1, 128'h1000);
    rd(LC, 4'h5, G1, 128'h11);
    frame(1'b0, 32'h0, 1'b1, 2'h0);
    end_of_test();
  end
endmodule
